//--- design/erpc_pkg.sv
// Package for the error resume address capture block
package erpc_pkg;

  localparam int unsigned ERPC_WIDTH = 64;
  localparam int unsigned ERPC_MODE_BIT = 0;

  // Classes of error exception sharing one resume register
  typedef enum logic [1:0] {
    ERPC_CAUSE_RESET = 2'b00,
    ERPC_CAUSE_SOFT_RESET = 2'b01,
    ERPC_CAUSE_NMI = 2'b10,
    ERPC_CAUSE_CACHE_ERR = 2'b11
  } erpc_cause_type;

  // Hardware capture request from the exception logic
  typedef struct packed {
    logic valid;
    erpc_cause_type cause;
    logic in_delay_slot;
    logic [ERPC_WIDTH-1:0] fault_pc;
    logic [ERPC_WIDTH-1:0] branch_pc;
    logic isa_mode;
  } erpc_capture_type;

  // Software access on the coprocessor register port
  typedef struct packed {
    logic wr_en;
    logic [ERPC_WIDTH-1:0] wr_data;
  } erpc_sw_write_type;

  // Redirect produced by the error return instruction
  typedef struct packed {
    logic valid;
    logic [ERPC_WIDTH-1:0] pc;
    logic isa_mode;
  } erpc_redirect_type;

  // Capture state machine
  typedef enum logic [1:0] {
    ERPC_ST_EMPTY = 2'b00,
    ERPC_ST_HW = 2'b01,
    ERPC_ST_SW = 2'b10
  } erpc_state_type;

  localparam erpc_state_type ERPC_STATE_RESET = ERPC_ST_EMPTY;

endpackage : erpc_pkg

//--- design/erpc_resume_split.sv
// Splits a stored resume word into fetch address and mode bit
module erpc_resume_split
  import erpc_pkg::*;
#(
  parameter bit HAS_COMPRESSED = 1'b1
) (
  input wire logic [ERPC_WIDTH-1:0] stored,
  output logic [ERPC_WIDTH-1:0] pc,
  output logic isa_mode
);

  // Bit 0 only means mode when the compressed set exists
  always_comb begin
    if (HAS_COMPRESSED) begin
      pc = {stored[ERPC_WIDTH-1:1], 1'b0};
      isa_mode = stored[ERPC_MODE_BIT];
    end else begin
      pc = stored;
      isa_mode = 1'b0;
    end
  end

endmodule : erpc_resume_split

//--- design/erpc_top.sv
// Error resume address register with capture and return redirect
module erpc_top
  import erpc_pkg::*;
#(
  parameter bit HAS_COMPRESSED = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire erpc_capture_type capture,
  input wire erpc_sw_write_type sw_write,
  input wire logic exception_return_instruction_req,
  output logic [ERPC_WIDTH-1:0] sw_rd_data,
  output erpc_redirect_type redirect,
  output erpc_state_type src_state,
  output erpc_cause_type last_cause
);

  logic [ERPC_WIDTH-1:0] resume_q;
  logic [ERPC_WIDTH-1:0] resume_d;
  erpc_state_type state_q;
  erpc_state_type state_d;
  erpc_cause_type cause_q;
  erpc_cause_type cause_d;
  erpc_redirect_type redir_q;
  erpc_redirect_type redir_d;
  logic [ERPC_WIDTH-1:0] split_pc;
  logic split_mode;
  logic [ERPC_WIDTH-1:0] cap_addr;

  // Pick the resume address the hardware would store
  function automatic logic [ERPC_WIDTH-1:0] capture_word(
    input erpc_capture_type c,
    input bit compressed
  );
    logic [ERPC_WIDTH-1:0] a;
    a = c.in_delay_slot ? c.branch_pc : c.fault_pc;
    if (compressed) begin
      a = {a[ERPC_WIDTH-1:1], c.isa_mode};
    end
    return a;
  endfunction : capture_word

  assign cap_addr = capture_word(capture, HAS_COMPRESSED);

  // Resume word: no reset, since its content is undefined anyway
  always_comb begin
    resume_d = resume_q;
    if (capture.valid) begin
      resume_d = cap_addr;
    end else if (sw_write.wr_en) begin
      resume_d = sw_write.wr_data;
    end
  end

  // Plain flop; reset leaves value alone
  always_ff @(posedge clk) begin
    resume_q <= resume_d;
  end

  // Source tracker and last cause, useful for debug visibility
  always_comb begin
    state_d = state_q;
    cause_d = cause_q;
    case (state_q)
      ERPC_ST_EMPTY, ERPC_ST_HW, ERPC_ST_SW: begin
        if (capture.valid) begin
          state_d = ERPC_ST_HW;
          cause_d = capture.cause;
        end else if (sw_write.wr_en) begin
          state_d = ERPC_ST_SW;
        end
      end
      default: begin
        state_d = ERPC_ST_EMPTY;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ERPC_STATE_RESET;
      cause_q <= ERPC_CAUSE_RESET;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
    end
  end

  // Interpretation of the word happens only on return
  erpc_resume_split #(
    .HAS_COMPRESSED(HAS_COMPRESSED)
  ) u_split (
    .stored(resume_q),
    .pc(split_pc),
    .isa_mode(split_mode)
  );

  // Redirect registered one cycle after the return request
  always_comb begin
    redir_d.valid = exception_return_instruction_req;
    redir_d.pc = exception_return_instruction_req ? split_pc : redir_q.pc;
    redir_d.isa_mode = exception_return_instruction_req ? split_mode : redir_q.isa_mode;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      redir_q <= '0;
    end else begin
      redir_q <= redir_d;
    end
  end

  // Software sees the raw word, mode bit included
  assign sw_rd_data = resume_q;
  assign redirect = redir_q;
  assign src_state = state_q;
  assign last_cause = cause_q;

  // Capture lands next cycle with chosen address
  a_capture_addr: assert property (@(posedge clk) disable iff (rst)
    capture.valid |=> sw_rd_data == $past(cap_addr))
    else $error("capture address not stored");

  // Delay slot selects the branch address
  a_delay_slot: assert property (@(posedge clk) disable iff (rst)
    capture.valid && capture.in_delay_slot |=>
      sw_rd_data[ERPC_WIDTH-1:1] ==
      $past(capture.branch_pc[ERPC_WIDTH-1:1]))
    else $error("delay slot capture wrong");

  // Hardware wins over software in the same cycle
  a_hw_priority: assert property (@(posedge clk) disable iff (rst)
    capture.valid && sw_write.wr_en |=>
      sw_rd_data != $past(sw_write.wr_data) ||
      $past(cap_addr) == $past(sw_write.wr_data))
    else $error("software write beat hardware capture");

  // Software write stored verbatim
  a_sw_verbatim: assert property (@(posedge clk) disable iff (rst)
    sw_write.wr_en && !capture.valid |=>
      sw_rd_data == $past(sw_write.wr_data))
    else $error("software write not verbatim");

  // Value holds with no writer
  a_hold_value: assert property (@(posedge clk) disable iff (rst)
    !capture.valid && !sw_write.wr_en |=> $stable(sw_rd_data))
    else $error("resume word changed spontaneously");

  // Return pulse follows request by one cycle
  a_exception_return_instruction_pulse: assert property (@(posedge clk) disable iff (rst)
    exception_return_instruction_req |=> redirect.valid)
    else $error("redirect missing after return");

  // Redirect address has bit 0 clear with the compressed set
  a_redir_split: assert property (@(posedge clk) disable iff (rst)
    exception_return_instruction_req && HAS_COMPRESSED |=>
      redirect.pc == {$past(sw_rd_data[ERPC_WIDTH-1:1]), 1'b0} &&
      redirect.isa_mode == $past(sw_rd_data[0]))
    else $error("redirect split wrong");

  // Mode bit captured into bit 0
  a_mode_bit: assert property (@(posedge clk) disable iff (rst)
    capture.valid && HAS_COMPRESSED |=>
      sw_rd_data[0] == $past(capture.isa_mode))
    else $error("mode bit not captured");

  // Cause recorded for any error class
  a_cause_rec: assert property (@(posedge clk) disable iff (rst)
    capture.valid |=> last_cause == $past(capture.cause) &&
      src_state == ERPC_ST_HW)
    else $error("error cause not recorded");

endmodule : erpc_top

//--- dv/erpc_partner.sv
// Exception and fetch side model that drives the error resume block
module erpc_partner
  import erpc_pkg::*;
(
  input wire logic clk,
  output erpc_capture_type capture,
  output erpc_sw_write_type sw_write,
  output logic exception_return_instruction_req
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle at time zero
  initial begin
    capture = '0;
    sw_write = '0;
    exception_return_instruction_req = 1'b0;
  end

  // One request cycle; the next edge clears the strobes
  // Stale fields are inverted so a late sample cannot pass by luck
  task automatic drive(input erpc_capture_type c,
    input erpc_sw_write_type w, input logic e);
    @(posedge clk);
    capture <= c;
    sw_write <= w;
    exception_return_instruction_req <= e;
    @(posedge clk);
    capture <= {1'b0, ~c[$bits(erpc_capture_type)-2:0]};
    sw_write <= {1'b0, ~w.wr_data};
    exception_return_instruction_req <= 1'b0;
  endtask : drive
endmodule : erpc_partner

//--- dv/erpc_top_bench.sv
// Self-checking bench for the error resume block
module erpc_top_bench
  import erpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
  err_total++; $display("[FAIL] %s exp %h got %h", nm, exp, got); end end

  typedef struct packed {
    erpc_cause_type cause;
    logic ds;
    logic mode;
    logic [ERPC_WIDTH-1:0] exp;
  } erpc_row_type;

  localparam logic [ERPC_WIDTH-1:0] FPC = 64'hFFFF_0000_1234_5670;
  localparam logic [ERPC_WIDTH-1:0] BPC = 64'h0000_FFFF_8765_4321;
  localparam logic [ERPC_WIDTH-1:0] WV = 64'hA5A5_5A5A_C3C3_3C3D;

  logic clk;
  logic rst;
  erpc_capture_type capture;
  erpc_sw_write_type sw_write;
  logic exception_return_instruction_req;
  logic [ERPC_WIDTH-1:0] sw_rd_data;
  erpc_redirect_type redirect;
  erpc_state_type src_state;
  erpc_cause_type last_cause;
  int err_total = 0;
  int num_checks = 0;
  logic [ERPC_WIDTH-1:0] w;
  // Selected address with the mode folded into bit 0
  erpc_row_type rows [4] = '{
    '{ERPC_CAUSE_RESET, 1'b0, 1'b1, 64'hFFFF_0000_1234_5671},
    '{ERPC_CAUSE_SOFT_RESET, 1'b1, 1'b0, 64'h0000_FFFF_8765_4320},
    '{ERPC_CAUSE_NMI, 1'b0, 1'b0, 64'hFFFF_0000_1234_5670},
    '{ERPC_CAUSE_CACHE_ERR, 1'b1, 1'b1, 64'h0000_FFFF_8765_4321}};

  erpc_partner erpc_partner_inst (.clk(clk), .capture(capture),
    .sw_write(sw_write), .exception_return_instruction_req(exception_return_instruction_req));
  erpc_top erpc_top_inst (.clk(clk), .rst(rst), .capture(capture),
    .sw_write(sw_write), .exception_return_instruction_req(exception_return_instruction_req), .sw_rd_data(sw_rd_data),
    .redirect(redirect), .src_state(src_state), .last_cause(last_cause));

  // 26 ns period clock: the 12.5 ns half period rounds to 13 ns at 1 ns precision
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic close_out;
    if (err_total == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  // Error return, then the one-cycle redirect pulse
  task automatic ret_chk(input logic [ERPC_WIDTH-1:0] word);
    erpc_partner_inst.drive('0, '0, 1'b1);
    #1;
    `CHK("rd_valid", 1'b1, redirect.valid)
    `CHK("rd_pc", {word[63:1], 1'b0}, redirect.pc)
    `CHK("rd_mode", word[0], redirect.isa_mode)
    @(posedge clk);
    #1;
    `CHK("rd_drop", 1'b0, redirect.valid)
  endtask : ret_chk

  initial begin
    rst = 1'b1;
    repeat (10) @(posedge clk);
    // Content of the word itself is left unchecked here
    `CHK("rst_state", ERPC_ST_EMPTY, src_state)
    `CHK("rst_valid", 1'b0, redirect.valid)
    rst <= 1'b0;
    // Each error cause once, covering each delay slot and mode combination
    foreach (rows[i]) begin
      erpc_partner_inst.drive({1'b1, rows[i].cause, rows[i].ds, FPC, BPC,
        rows[i].mode}, '0, 1'b0);
      #1;
      `CHK("cap_word", rows[i].exp, sw_rd_data)
      `CHK("cap_cause", rows[i].cause, last_cause)
      `CHK("cap_state", ERPC_ST_HW, src_state)
      ret_chk(rows[i].exp);
    end
    // Software writes of a pattern and its inverse reach every bit
    for (int k = 0; k < 2; k++) begin
      w = (k == 0) ? WV : ~WV;
      erpc_partner_inst.drive('0, {1'b1, w}, 1'b0);
      #1;
      `CHK("sw_word", w, sw_rd_data)
      `CHK("sw_state", ERPC_ST_SW, src_state)
      ret_chk(w);
    end
    // Capture and write in one cycle: the capture must win
    erpc_partner_inst.drive({1'b1, ERPC_CAUSE_NMI, 1'b1, FPC, BPC, 1'b0},
      {1'b1, WV}, 1'b0);
    #1;
    `CHK("pri_word", 64'h0000_FFFF_8765_4320, sw_rd_data)
    `CHK("pri_state", ERPC_ST_HW, src_state)
    close_out();
  end
endmodule : erpc_top_bench
